/* File: hdl/ext_irq_pkg.sv */
// constants, types and layout for the two-channel external edge interrupt block
// assumes one 100 MHz peripheral clock and a simple internal write strobe to the i/o space
package ext_irq_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] EXT_IRQ0_CONTROL_ADDR = 8'h98;
   localparam logic [7:0] EXT_IRQ1_CONTROL_ADDR = 8'h99;
   localparam logic [7:0] CONTROL_RESET = 8'h00;

   // ==========================================================
   // control field positions
   localparam int PRIO_LSB = 0;
   localparam int LOW_EDGE_LSB = 2;
   localparam int HIGH_EDGE_LSB = 4;

   // ==========================================================
   // vector table offsets
   localparam logic [11:0] VECTOR_OFFSET_CH0 = 12'h000;
   localparam logic [11:0] VECTOR_OFFSET_CH1 = 12'h010;

   // ==========================================================
   // timing
   localparam int SYNC_STAGES = 2;
   localparam int MIN_PULSE_CYCLES = 3;
   localparam int CPU_LATENCY_CLOCKS = 10;

   typedef enum logic [1:0] {
      EDGE_OFF,
      EDGE_FALL,
      EDGE_RISE,
      EDGE_BOTH
   } edge_sel_t;

endpackage

/* File: hdl/external_edge_interrupts.sv */
// two external edge interrupt channels with clock-sampled edge detectors, priority and auto-clearing requests
// assumes the processor core supplies write strobe, current priority and an acknowledge pulse
`timescale 1ns/1ns

module external_edge_interrupts
   import ext_irq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic ioWrite,
   input wire logic [7:0] ioAddr,
   input wire logic [7:0] ioWdata,
   input wire logic porte_line_0,
   input wire logic porte_line_1,
   input wire logic porte_line_4,
   input wire logic porte_line_5,
   input wire logic [1:0] cpuPriority,
   input wire logic irqAck,
   output logic irqReq,
   output logic [1:0] irqPriority,
   output logic [11:0] irqVectorOffset,
   output logic [1:0] pendingOut
);

   // ==========================================================
   // helpers
   function automatic logic edgeHit(input logic [1:0] sel, input logic prev, input logic cur);
      logic rise;
      logic fall;
      rise = ~prev & cur;
      fall = prev & ~cur;
      case (edge_sel_t'(sel))
         EDGE_FALL: edgeHit = fall;
         EDGE_RISE: edgeHit = rise;
         EDGE_BOTH: edgeHit = rise | fall;
         default: edgeHit = 1'b0;
      endcase
   endfunction

   // ==========================================================
   // control registers, write only
   logic [7:0] ctrl_q [2];
   logic [3:0] pins;
   assign pins = {porte_line_5, porte_line_4, porte_line_1, porte_line_0};

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q[0] <= CONTROL_RESET;
         ctrl_q[1] <= CONTROL_RESET;
      end else if (ioWrite) begin
         // reserved bits are stored as zero since nothing reads them back
         if (ioAddr == EXT_IRQ0_CONTROL_ADDR) begin
            ctrl_q[0] <= {2'b00, ioWdata[5:0]};
         end
         if (ioAddr == EXT_IRQ1_CONTROL_ADDR) begin
            ctrl_q[1] <= {2'b00, ioWdata[5:0]};
         end
      end
   end

   // ==========================================================
   // pin synchronisers and catchers on the peripheral clock
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [3:0] prev_q;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         prev_q <= 4'h0;
      end else begin
         // a pulse shorter than one clock may slip between samples
         sync1_q <= pins;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // ==========================================================
   // per channel request latch
   logic [1:0] pending_q;
   logic [1:0] hit;
   logic [1:0] ackCh;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         logic lowHit;
         logic highHit;
         // lower pin is line ch, upper pin is line ch+4
         assign lowHit = edgeHit(ctrl_q[ch][LOW_EDGE_LSB +: 2], prev_q[ch], sync2_q[ch]);
         assign highHit = edgeHit(ctrl_q[ch][HIGH_EDGE_LSB +: 2], prev_q[ch + 2],
                                  sync2_q[ch + 2]);
         assign hit[ch] = lowHit | highHit;

         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               pending_q[ch] <= 1'b0;
            end else if (hit[ch]) begin
               // a new edge wins over an acknowledge in the same cycle
               pending_q[ch] <= 1'b1;
            end else if (ackCh[ch]) begin
               pending_q[ch] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================
   // arbitration toward the processor
   logic [1:0] prio0;
   logic [1:0] prio1;
   logic [1:0] eligible;
   assign prio0 = ctrl_q[0][PRIO_LSB +: 2];
   assign prio1 = ctrl_q[1][PRIO_LSB +: 2];
   // priority 00 can never exceed cpuPriority, so it disables the channel
   assign eligible[0] = pending_q[0] && (prio0 > cpuPriority);
   assign eligible[1] = pending_q[1] && (prio1 > cpuPriority);

   logic winner;
   assign winner = eligible[1]; // channel 1 first
   assign ackCh[1] = irqAck && eligible[1];
   assign ackCh[0] = irqAck && eligible[0] && !eligible[1];

   // request goes to the core ahead of internal sources; the core adds its own
   // fixed entry latency after detection
   assign irqReq = |eligible;
   assign irqPriority = !irqReq ? 2'b00 : (winner ? prio1 : prio0);
   assign irqVectorOffset = winner ? VECTOR_OFFSET_CH1 : VECTOR_OFFSET_CH0;
   assign pendingOut = pending_q;

endmodule // external_edge_interrupts

/* File: bench/ext_irq_assertions.sv */
// checker for the external edge interrupt block, bound to its top
// assumes one clock domain and the top's own port names
`timescale 1ns/1ns
module ext_irq_chk(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [1:0] cpuPriority,
   input wire logic irqAck,
   input wire logic irqReq,
   input wire logic [1:0] irqPriority,
   input wire logic [11:0] irqVectorOffset,
   input wire logic [1:0] pendingOut
);
   // ====
   // checks
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   chk_req_above_cpu: assert property (irqReq |-> irqPriority > cpuPriority)
      else $error("request at or below cpu level");
   chk_idle_no_req: assert property (pendingOut == 2'h0 |-> !irqReq)
      else $error("request with nothing pending");
   chk_idle_prio: assert property (!irqReq |-> irqPriority == 2'h0)
      else $error("priority shown without request");
   chk_vec_ch1: assert property (irqReq && irqVectorOffset == 12'h010 |-> pendingOut[1])
      else $error("ch1 vector without ch1 pending");
   chk_vec_ch0: assert property (irqReq && irqVectorOffset == 12'h000 |-> pendingOut[0])
      else $error("ch0 vector without ch0 pending");
   chk_ack_clears: assert property (irqAck && irqReq |=> pendingOut != $past(pendingOut))
      else $error("acknowledge left request set");
   chk_hold_ch0: assert property (pendingOut[0] && !irqAck |=> pendingOut[0])
      else $error("ch0 request dropped");
   chk_hold_ch1: assert property (pendingOut[1] && !irqAck |=> pendingOut[1])
      else $error("ch1 request dropped");
endmodule // ext_irq_chk
bind external_edge_interrupts ext_irq_chk u_ext_irq_chk(.sys_clk(sys_clk), .resetn(resetn), .cpuPriority(cpuPriority),
   .irqAck(irqAck), .irqReq(irqReq), .irqPriority(irqPriority), .irqVectorOffset(irqVectorOffset),
   .pendingOut(pendingOut));

/* File: bench/pin_source.sv */
// peripheral pin source driving the four interrupt pins
// assumes the bench spaces level changes at least three clocks apart
`timescale 1ns/1ns
module pin_source(
   input wire logic sys_clk,
   input wire logic [3:0] want,
   output logic [3:0] pins
);
   // ====
   // pins
   initial pins = 4'h0;
   always @(posedge sys_clk) pins <= want;
endmodule // pin_source

/* File: bench/tb.sv */
// self-checking bench for the external edge interrupt block
// assumes the pin source model and the checker compile first
`timescale 1ns/1ns
module tb;
   import ext_irq_pkg::*;
   // ====
   // stimulus and model
   logic sys_clk = 0, resetn = 0, ioWrite = 0, irqAck = 0, irqReq;
   logic [7:0] ioAddr = 0, ioWdata = 0, ctrl[2];
   logic [1:0] cpuPriority = 0, irqPriority, pendingOut, expPend = 0;
   logic [3:0] want = 0, pins, prevPins = 0;
   logic [11:0] irqVectorOffset;
   int n_mismatch = 0, cmp_count = 0, w;
   always #5 sys_clk = ~sys_clk;
   pin_source u_pin_source(.sys_clk(sys_clk), .want(want), .pins(pins));
   external_edge_interrupts u_external_edge_interrupts(.sys_clk(sys_clk), .resetn(resetn), .ioWrite(ioWrite),
      .ioAddr(ioAddr), .ioWdata(ioWdata), .porte_line_0(pins[0]), .porte_line_1(pins[1]), .porte_line_4(pins[2]),
      .porte_line_5(pins[3]), .cpuPriority(cpuPriority), .irqAck(irqAck), .irqReq(irqReq),
      .irqPriority(irqPriority), .irqVectorOffset(irqVectorOffset), .pendingOut(pendingOut));
   task automatic print_verdict();
      if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(logic [11:0] got, logic [11:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic int win();
      if (expPend[1] && ctrl[1][1:0] > cpuPriority) return 1;
      if (expPend[0] && ctrl[0][1:0] > cpuPriority) return 0;
      return 2;
   endfunction
   task automatic check();
      w = win();
      cmp(pendingOut, expPend);
      cmp(irqReq, w < 2);
      cmp(irqPriority, w < 2 ? ctrl[w][1:0] : 2'h0);
      if (w < 2) cmp(irqVectorOffset, w ? 12'h010 : 12'h000);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge sys_clk);
      ioWrite <= 1'h1;
      ioAddr <= a;
      ioWdata <= d;
      if (a < 8'h9a) ctrl[a[0]] = d;
      @(posedge sys_clk);
      ioWrite <= 1'h0;
   endtask
   initial begin
      ctrl[0] = 8'h00;
      ctrl[1] = 8'h00;
      void'($urandom(32'h0cf7));
      repeat (3) @(posedge sys_clk);
      resetn <= 1'h1;
      repeat (300) begin
         for (int a = 0; a < 3; a++) wr(8'h98 + a, $urandom);
         cpuPriority <= $urandom;
         want <= $urandom;
         repeat (6) @(posedge sys_clk);
         // rising needs the upper code bit, falling the lower one
         for (int k = 0; k < 4; k++) if (want[k] !== prevPins[k] && ctrl[k % 2][(k < 2 ? 2 : 4) + want[k]])
            expPend[k % 2] = 1'h1;
         prevPins = want;
         #1 check();
         if (w < 2) begin
            @(posedge sys_clk) irqAck <= 1'h1;
            @(posedge sys_clk) irqAck <= 1'h0;
            expPend[w] = 1'h0;
            #1 check();
         end
      end
      print_verdict();
   end
   initial begin
      #100000;
      n_mismatch++;
      print_verdict();
   end
endmodule // tb
